/* File: src/evd_decoder.sv */
`timescale 1ns/1ps
module evd_decoder (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    // Vector base register write port
    input  wire logic                        vbr_write,
    input  wire logic [7:0]                  vbr_wdata,
    output logic      [7:0]                  vector_base_register,
    // Requests and core state
    input  wire evd_pkg::evd_req_s           req,
    input  wire logic [evd_pkg::NUM_IRQ-1:0] irq_enable,
    input  wire evd_pkg::evd_cond_s          core_condition_codes,
    input  wire logic                        background_debug,
    // Vector handshake
    input  wire logic                        vector_request,
    output logic      [15:0]                 vector_addr,
    output logic                             vector_valid,
    output evd_pkg::evd_src_e                vector_source,
    // Wake-up
    output logic                             wake_up
);

    localparam int NI = evd_pkg::NUM_IRQ;

    logic [7:0]  vector_base_upper_byte;
    logic [15:0] vector_base;
    logic [NI-1:0] irq_active;
    logic        irq_any;
    logic [7:0]  irq_offset;
    logic        hi_pending;
    logic        irq_allowed;
    logic        xirq_allowed;
    logic [15:0] next_vector_addr;
    evd_pkg::evd_src_e next_source;

    // Base register, software writable
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vector_base_register <= evd_pkg::VBR_RESET;
        end else if (vbr_write) begin
            vector_base_register <= vbr_wdata;
        end
    end

    assign vector_base_upper_byte = background_debug
        ? evd_pkg::VBR_DEBUG : vector_base_register;
    assign vector_base = {vector_base_upper_byte,
        evd_pkg::BASE_LOW};

    // Line k maps to base+0x82+2k; higher k wins
    assign irq_active = req.irq & irq_enable;
    assign irq_any    = |irq_active;

    always_comb begin
        irq_offset = evd_pkg::OFF_IRQ_FIRST;
        for (int k = 0; k < NI; k++) begin
            if (irq_active[k]) begin
                irq_offset = 8'(evd_pkg::OFF_IRQ_FIRST
                    + 2 * k);
            end
        end
    end

    assign hi_pending = req.trap | req.software_interrupt_request
        | req.xirq;
    assign xirq_allowed = req.xirq & ~core_condition_codes.x_mask;
    // Masked high requests still block I-level service
    assign irq_allowed = irq_any & ~core_condition_codes.i_mask
        & ~hi_pending;

    // Fixed priority chain, highest vector first
    always_comb begin
        next_vector_addr = {vector_base_upper_byte,
            evd_pkg::OFF_SPURIOUS};
        next_source = evd_pkg::EVD_SRC_NONE;
        if (req.rst_power) begin
            next_vector_addr = evd_pkg::VEC_RST_POWER;
            next_source = evd_pkg::EVD_SRC_RST_POWER;
        end else if (req.rst_clkmon) begin
            next_vector_addr = evd_pkg::VEC_RST_CLKMON;
            next_source = evd_pkg::EVD_SRC_RST_CLKMON;
        end else if (req.rst_wdog) begin
            next_vector_addr = evd_pkg::VEC_RST_WDOG;
            next_source = evd_pkg::EVD_SRC_RST_WDOG;
        end else if (req.trap) begin
            next_vector_addr = vector_base | 16'(evd_pkg::OFF_TRAP);
            next_source = evd_pkg::EVD_SRC_TRAP;
        end else if (req.software_interrupt_request) begin
            next_vector_addr = vector_base | 16'(evd_pkg::OFF_SOFT);
            next_source = evd_pkg::EVD_SRC_SOFT;
        end else if (xirq_allowed) begin
            next_vector_addr = vector_base | 16'(evd_pkg::OFF_XIRQ);
            next_source = evd_pkg::EVD_SRC_XIRQ;
        end else if (irq_allowed) begin
            next_vector_addr = vector_base | 16'(irq_offset);
            next_source = evd_pkg::EVD_SRC_IRQ;
        end
    end

    // Vector captured only when the core asks
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            vector_addr   <= 16'h0000;
            vector_valid  <= 1'b0;
            vector_source <= evd_pkg::EVD_SRC_NONE;
        end else begin
            vector_valid <= vector_request;
            if (vector_request) begin
                vector_addr   <= next_vector_addr;
                vector_source <= next_source;
            end
        end
    end

    // Wake is purely combinational so it works with the clock gated
    assign wake_up = req.rst_power | req.rst_clkmon | req.rst_wdog
        | req.trap | req.software_interrupt_request | xirq_allowed
        | (irq_any & ~core_condition_codes.i_mask);

    // Assertions
    property p_vbr_reset;
        @(posedge sys_clk) $fell(rst) |-> vector_base_register == 8'hFF;
    endproperty
    a_vbr_reset: assert property (p_vbr_reset)
        else $error("base register not 0xFF after reset");

    property p_valid_follows;
        @(posedge sys_clk) disable iff (rst)
            vector_request |=> vector_valid
                && vector_addr == $past(next_vector_addr);
    endproperty
    a_valid_follows: assert property (p_valid_follows)
        else $error("vector not delivered after request");

    property p_hold;
        @(posedge sys_clk) disable iff (rst)
            !vector_request |=> $stable(vector_addr) && !vector_valid;
    endproperty
    a_hold: assert property (p_hold)
        else $error("vector changed without request");

    property p_debug_base;
        @(posedge sys_clk) disable iff (rst)
            vector_request && background_debug && !req.rst_power
            && !req.rst_clkmon && !req.rst_wdog
            |=> vector_addr[15:8] == 8'hFF;
    endproperty
    a_debug_base: assert property (p_debug_base)
        else $error("debug base not forced");

    property p_reset_vec;
        @(posedge sys_clk) disable iff (rst)
            vector_request && req.rst_power |=> vector_addr == 16'hFFFE;
    endproperty
    a_reset_vec: assert property (p_reset_vec)
        else $error("power reset vector wrong");

    property p_spurious;
        @(posedge sys_clk) disable iff (rst)
            vector_request && !wake_up && !req.xirq
            |=> vector_addr[7:0] == 8'h80
                && vector_source == evd_pkg::EVD_SRC_NONE;
    endproperty
    a_spurious: assert property (p_spurious)
        else $error("spurious vector missing");

    property p_soft_over_irq;
        @(posedge sys_clk) disable iff (rst)
            vector_request && req.software_interrupt_request && !req.trap
            && !req.rst_power && !req.rst_clkmon && !req.rst_wdog
            |=> vector_addr[7:0] == 8'hF6;
    endproperty
    a_soft_over_irq: assert property (p_soft_over_irq)
        else $error("software vector wrong");

    property p_irq_masked;
        @(posedge sys_clk) disable iff (rst)
            vector_request && core_condition_codes.i_mask
            |=> vector_source != evd_pkg::EVD_SRC_IRQ;
    endproperty
    a_irq_masked: assert property (p_irq_masked)
        else $error("masked I request serviced");

    property p_irq_range;
        @(posedge sys_clk) disable iff (rst)
            vector_source == evd_pkg::EVD_SRC_IRQ |->
            vector_addr[7:0] >= 8'h82 && vector_addr[7:0] <= 8'hF2;
    endproperty
    a_irq_range: assert property (p_irq_range)
        else $error("I vector out of range");

    property p_wake;
        @(posedge sys_clk) disable iff (rst)
            req.trap |-> wake_up;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake on trap");

    property p_trap_vec;
        @(posedge sys_clk) disable iff (rst)
            vector_request && req.trap && !req.rst_power
            && !req.rst_clkmon && !req.rst_wdog
            |=> vector_addr[7:0] == evd_pkg::OFF_TRAP
                && vector_source == evd_pkg::EVD_SRC_TRAP;
    endproperty
    a_trap_vec: assert property (p_trap_vec)
        else $error("trap vector wrong");

    property p_xirq_vec;
        @(posedge sys_clk) disable iff (rst)
            vector_request && req.xirq && !core_condition_codes.x_mask
            && !req.trap && !req.software_interrupt_request
            && !req.rst_power && !req.rst_clkmon && !req.rst_wdog
            |=> vector_addr[7:0] == evd_pkg::OFF_XIRQ;
    endproperty
    a_xirq_vec: assert property (p_xirq_vec)
        else $error("X-maskable vector wrong");

    property p_base_upper;
        @(posedge sys_clk) disable iff (rst)
            vector_request && !background_debug && !req.rst_power
            && !req.rst_clkmon && !req.rst_wdog
            |=> vector_addr[15:8] == $past(vector_base_register);
    endproperty
    a_base_upper: assert property (p_base_upper)
        else $error("vector upper byte not from base register");

    property p_debug_keeps;
        @(posedge sys_clk) disable iff (rst)
            background_debug && !vbr_write
            |=> vector_base_register == $past(vector_base_register);
    endproperty
    a_debug_keeps: assert property (p_debug_keeps)
        else $error("base register changed in debug");

    property p_clkmon_vec;
        @(posedge sys_clk) disable iff (rst)
            vector_request && req.rst_clkmon && !req.rst_power
            |=> vector_addr == evd_pkg::VEC_RST_CLKMON;
    endproperty
    a_clkmon_vec: assert property (p_clkmon_vec)
        else $error("clock monitor reset vector wrong");

    property p_wdog_vec;
        @(posedge sys_clk) disable iff (rst)
            vector_request && req.rst_wdog && !req.rst_power
            && !req.rst_clkmon
            |=> vector_addr == evd_pkg::VEC_RST_WDOG;
    endproperty
    a_wdog_vec: assert property (p_wdog_vec)
        else $error("watchdog reset vector wrong");

    property p_irq_blocked;
        @(posedge sys_clk) disable iff (rst)
            vector_request
            && (req.trap || req.software_interrupt_request || req.xirq)
            |=> vector_source != evd_pkg::EVD_SRC_IRQ;
    endproperty
    a_irq_blocked: assert property (p_irq_blocked)
        else $error("I request served over higher request");

    property p_irq_top;
        @(posedge sys_clk) disable iff (rst)
            vector_request && req.irq[NI-1] && irq_enable[NI-1]
            && !core_condition_codes.i_mask && !hi_pending
            && !req.rst_power && !req.rst_clkmon && !req.rst_wdog
            |=> vector_addr[7:0] == evd_pkg::OFF_IRQ_LAST;
    endproperty
    a_irq_top: assert property (p_irq_top)
        else $error("highest I line did not win");

    property p_wake_irq;
        @(posedge sys_clk) disable iff (rst)
            irq_any && !core_condition_codes.i_mask |-> wake_up;
    endproperty
    a_wake_irq: assert property (p_wake_irq)
        else $error("no wake on enabled I request");

    property p_wake_quiet;
        @(posedge sys_clk) disable iff (rst)
            !req.rst_power && !req.rst_clkmon && !req.rst_wdog
            && !req.trap && !req.software_interrupt_request
            && !xirq_allowed && !irq_any |-> !wake_up;
    endproperty
    a_wake_quiet: assert property (p_wake_quiet)
        else $error("wake without any request");

    c_irq: cover property (@(posedge sys_clk) disable iff (rst)
        vector_source == evd_pkg::EVD_SRC_IRQ);
    c_xirq: cover property (@(posedge sys_clk) disable iff (rst)
        vector_source == evd_pkg::EVD_SRC_XIRQ);
    c_spur: cover property (@(posedge sys_clk) disable iff (rst)
        vector_valid && vector_source == evd_pkg::EVD_SRC_NONE);
    c_dbg: cover property (@(posedge sys_clk) disable iff (rst)
        vector_request && background_debug);
    c_reset: cover property (@(posedge sys_clk) disable iff (rst)
        vector_source == evd_pkg::EVD_SRC_RST_POWER);

endmodule // evd_decoder

/* File: src/evd_pkg.sv */
package evd_pkg;

    // Number of I-maskable request lines (base+0x82 .. base+0xF2)
    localparam int NUM_IRQ = 57;

    localparam logic [7:0]  VBR_RESET       = 8'hFF;
    localparam logic [7:0]  VBR_DEBUG       = 8'hFF;
    localparam logic [7:0]  BASE_LOW        = 8'h00;
    localparam logic [7:0]  OFF_SPURIOUS    = 8'h80;
    localparam logic [7:0]  OFF_IRQ_FIRST   = 8'h82;
    localparam logic [7:0]  OFF_IRQ_LAST    = 8'hF2;
    localparam logic [7:0]  OFF_XIRQ        = 8'hF4;
    localparam logic [7:0]  OFF_SOFT        = 8'hF6;
    localparam logic [7:0]  OFF_TRAP        = 8'hF8;
    localparam logic [15:0] VEC_RST_POWER   = 16'hFFFE;
    localparam logic [15:0] VEC_RST_CLKMON  = 16'hFFFC;
    localparam logic [15:0] VEC_RST_WDOG    = 16'hFFFA;

    // Requests coming from the system toward the decoder
    typedef struct packed {
        logic               rst_power;
        logic               rst_clkmon;
        logic               rst_wdog;
        logic               trap;
        logic               software_interrupt_request;
        logic               xirq;
        logic [NUM_IRQ-1:0] irq;
    } evd_req_s;

    // Core condition code mask bits
    typedef struct packed {
        logic x_mask;
        logic i_mask;
    } evd_cond_s;

    typedef enum logic [3:0] {
        EVD_SRC_NONE,
        EVD_SRC_RST_POWER,
        EVD_SRC_RST_CLKMON,
        EVD_SRC_RST_WDOG,
        EVD_SRC_TRAP,
        EVD_SRC_SOFT,
        EVD_SRC_XIRQ,
        EVD_SRC_IRQ
    } evd_src_e;

endpackage

/* File: verif/evd_core_model.sv */
`timescale 1ns/1ps
module evd_core_model (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Command from the bench
    input  wire logic              ask,
    // Vector handshake
    output logic                   vector_request,
    input  wire logic              vector_valid,
    input  wire logic [15:0]       vector_addr,
    input  wire evd_pkg::evd_src_e vector_source,
    // Captured answer
    output logic [15:0]            seen_addr,
    output evd_pkg::evd_src_e      seen_src,
    output int                     seen_count
);
    // Request launched away from the sampling edge
    always @(negedge sys_clk or posedge rst) begin
        if (rst) begin
            vector_request <= 1'b0;
        end else begin
            vector_request <= ask;
        end
    end
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            seen_addr  <= 16'h0000;
            seen_src   <= evd_pkg::EVD_SRC_NONE;
            seen_count <= 0;
        end else if (vector_valid) begin
            seen_addr  <= vector_addr;
            seen_src   <= vector_source;
            seen_count <= seen_count + 1;
        end
    end
endmodule // evd_core_model

/* File: verif/exception_vector_decoder_tb_top.sv */
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
    checked++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("unexpected %s expected %h seen %h", what, exp, got); \
    end \
end
module exception_vector_decoder_tb_top;
    logic                         sys_clk, rst, vbr_write, dbg, ask;
    logic                         vector_request, vector_valid, wake_up;
    logic [7:0]                   vbr_wdata, vbr;
    logic [15:0]                  vector_addr, seen_addr;
    logic [evd_pkg::NUM_IRQ-1:0]  en;
    evd_pkg::evd_req_s            req;
    evd_pkg::evd_cond_s           cond;
    evd_pkg::evd_src_e            vector_source, seen_src;
    int                           seen_count, mismatches, checked;

    always #5 sys_clk = ~sys_clk;

    evd_decoder uut (.sys_clk(sys_clk), .rst(rst), .vbr_write(vbr_write),
        .vbr_wdata(vbr_wdata), .vector_base_register(vbr), .req(req),
        .irq_enable(en), .core_condition_codes(cond),
        .background_debug(dbg), .vector_request(vector_request),
        .vector_addr(vector_addr), .vector_valid(vector_valid),
        .vector_source(vector_source), .wake_up(wake_up));
    evd_core_model core (.sys_clk(sys_clk), .rst(rst), .ask(ask),
        .vector_request(vector_request), .vector_valid(vector_valid),
        .vector_addr(vector_addr), .vector_source(vector_source),
        .seen_addr(seen_addr), .seen_src(seen_src),
        .seen_count(seen_count));

    task complete_run;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task put(input evd_pkg::evd_req_s r, input logic [56:0] e,
             input logic [1:0] c, input logic d);
        @(negedge sys_clk);
        req = r;
        en = e;
        cond = c;
        dbg = d;
    endtask
    task vec(input string what, input logic [15:0] exp);
        int n;
        int i;
        n = seen_count;
        @(posedge sys_clk);
        #1 ask = 1'b1;
        @(posedge sys_clk);
        #1 ask = 1'b0;
        for (i = 0; i < 5 && seen_count == n; i++) begin
            @(posedge sys_clk);
            #1;
        end
        if (seen_count == n) begin
            mismatches++;
            complete_run();
        end else begin
            `CHK(what, exp, seen_addr)
            `CHK("valid pulse", 1'b0, vector_valid)
        end
    endtask
    task t_base;
        `CHK("base reset", 8'hFF, vbr)
        put('0, '1, 2'b00, 1'b0);
        vec("spurious", 16'hFF80);
        @(negedge sys_clk);
        vbr_write = 1'b1;
        vbr_wdata = 8'h12;
        @(negedge sys_clk);
        vbr_write = 1'b0;
        `CHK("base", 8'h12, vbr)
        vec("spurious base", 16'h1280);
    endtask
    task t_irq;
        evd_pkg::evd_req_s r;
        for (int k = 0; k < evd_pkg::NUM_IRQ; k++) begin
            r = '0;
            r.irq[k] = 1'b1;
            put(r, '1, 2'b00, 1'b0);
            vec("irq", {8'h12, 8'(8'h82 + 2 * k)});
        end
    endtask
    task t_prio;
        evd_pkg::evd_req_s r;
        logic [15:0] tbl [6];
        tbl = '{16'h12F4, 16'h12F6, 16'h12F8, 16'hFFFA, 16'hFFFC, 16'hFFFE};
        r = '0;
        r.irq = '1;
        put(r, '1, 2'b00, 1'b0);
        vec("all irq", 16'h12F2);
        for (int i = 0; i < 6; i++) begin
            r = evd_pkg::evd_req_s'(r | (63'h1 << (57 + i)));
            put(r, '1, 2'b00, 1'b0);
            vec("prio", tbl[i]);
        end
        `CHK("source", evd_pkg::EVD_SRC_RST_POWER, seen_src)
    endtask
    task t_mask;
        evd_pkg::evd_req_s r;
        r = '0;
        r.irq[5] = 1'b1;
        put(r, '1, 2'b01, 1'b0);
        #1;
        `CHK("wake masked", 1'b0, wake_up)
        vec("i masked", 16'h1280);
        put(r, '0, 2'b00, 1'b0);
        vec("not enabled", 16'h1280);
        put(r, '1, 2'b00, 1'b0);
        #1;
        `CHK("wake", 1'b1, wake_up)
        r.xirq = 1'b1;
        put(r, '1, 2'b10, 1'b0);
        vec("x masked blocks", 16'h1280);
        put(r, '1, 2'b00, 1'b0);
        vec("xirq", 16'h12F4);
        `CHK("source x", evd_pkg::EVD_SRC_XIRQ, seen_src)
    endtask
    task t_debug;
        evd_pkg::evd_req_s r;
        r = '0;
        r.software_interrupt_request = 1'b1;
        put(r, '1, 2'b11, 1'b1);
        vec("debug swi", 16'hFFF6);
        r.trap = 1'b1;
        put(r, '1, 2'b11, 1'b1);
        vec("debug trap", 16'hFFF8);
        `CHK("base kept", 8'h12, vbr)
        put(r, '1, 2'b11, 1'b0);
        vec("trap", 16'h12F8);
    endtask

    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        vbr_write = 1'b0;
        vbr_wdata = 8'h00;
        req = '0;
        en = '0;
        cond = '0;
        dbg = 1'b0;
        ask = 1'b0;
        mismatches = 0;
        checked = 0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        t_base();
        t_irq();
        t_prio();
        t_mask();
        t_debug();
        complete_run();
    end
endmodule // exception_vector_decoder_tb_top
